/* rtl/priority_interrupt_controller.sv */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Writing one to the global enable bit sets the global enable flag.
// - Disable, acknowledge, write of zero, reset and any trap clear enable.
// - Level 3 beats level 2 and level 2 beats level 1 regardless of source.
// - Within one level a fixed rank picks the winner, lowest index first.
// - Reset, watchdog, oscillator and illegal traps always sit at level 3.
// - A one-cycle request pulse is caught into a persistent pending flag.
// - An acknowledge clears that source's pending flag until its next pulse.
// - Software writing zero to a request bit clears that pending request.
// - Reset select zero makes a watchdog timeout a request gated by enable.
module priority_interrupt_controller
  import irq_ctrl_pkg::*;
#(
  parameter int unsigned N_SRC = NUM_SRC,
  parameter int unsigned WDT_SRC = 0
)(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // Sources
  input wire logic [N_SRC-1:0] src_pulse_i,
  input wire logic [N_SRC-1:0] src_is_trap_i,
  input wire logic [2*N_SRC-1:0] src_level_i,
  input wire logic watchdog_timeout_i,
  input wire logic watchdog_reset_select_i,
  // Software writes
  input wire logic [N_SRC-1:0] req_wr_zero_i,
  input wire gie_evt_t gie_evt_i,
  // Processor core
  input wire logic ack_i,
  input wire logic [ID_W-1:0] ack_id_i,
  output irq_req_t req_o,
  output logic global_irq_enable_o,
  output logic [N_SRC-1:0] pending_o,
  output logic watchdog_reset_o
);

  if (N_SRC != NUM_SRC || WDT_SRC >= N_SRC) begin : g_bad_cfg
    $error("unsupported source count or watchdog index");
  end

  logic gie_r;
  logic gie_nxt;
  logic gie_clr;
  logic [N_SRC-1:0] pend;
  logic [N_SRC-1:0] pulse;
  logic [N_SRC-1:0] ack_vec;
  logic [N_SRC-1:0] lvl3;
  logic [N_SRC-1:0] lvl2;
  logic [N_SRC-1:0] lvl1;
  logic [N_SRC-1:0] elig;
  logic [N_SRC-1:0] cand;
  logic [N_SRC-1:0] pick3;
  logic [N_SRC-1:0] pick2;
  logic [N_SRC-1:0] pick1;
  logic wdt_irq;
  logic any_trap_evt;

  // A watchdog timeout becomes a request only when reset is not selected.
  assign wdt_irq = watchdog_timeout_i && !watchdog_reset_select_i;
  // With reset selected the timeout leaves as a reset and posts nothing.
  assign watchdog_reset_o = watchdog_timeout_i && watchdog_reset_select_i;

  always_comb begin
    pulse = src_pulse_i;
    pulse[WDT_SRC] = src_pulse_i[WDT_SRC] | wdt_irq;
  end

  genvar g;
  generate
    for (g = 0; g < N_SRC; g++) begin : g_src
      irq_pend_bit u_pend (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .pulse_i(pulse[g]),
        .ack_clr_i(ack_vec[g]),
        .sw_clr_i(req_wr_zero_i[g]),
        .pend_o(pend[g])
      );
      assign ack_vec[g] = ack_i && (ack_id_i == ID_W'(g));
      // Traps and the watchdog are pinned to the top level.
      assign lvl3[g] = src_is_trap_i[g] || (g == WDT_SRC) ||
                       (src_level_i[2*g+:2] == LVL_3);
      assign lvl2[g] = !lvl3[g] && (src_level_i[2*g+:2] == LVL_2);
      assign lvl1[g] = !lvl3[g] && (src_level_i[2*g+:2] == LVL_1);
      // Without global enable only traps may be presented.
      assign elig[g] = pend[g] && (gie_r || src_is_trap_i[g]);
    end
  endgenerate

  // Pick the highest non-empty level, then the lowest index within it.
  // A source at level 0 stays pending but never reaches a pick vector.
  assign pick3 = elig & lvl3;
  assign pick2 = elig & lvl2;
  assign pick1 = elig & lvl1;
  assign cand = |pick3 ? pick3 :
                |pick2 ? pick2 :
                pick1;

  always_comb begin
    req_o = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (cand[i]) begin
        req_o.valid = 1'b1;
        req_o.id = ID_W'(i);
        req_o.trap = src_is_trap_i[i];
        req_o.level = lvl3[i] ? LVL_3 : src_level_i[2*i+:2];
      end
    end
  end

  // Any clearing event outranks a software write of one in the same cycle.
  assign any_trap_evt = gie_evt_i.trap_instruction ||
                        gie_evt_i.illegal_trap ||
                        gie_evt_i.prim_osc_fail ||
                        gie_evt_i.wdt_osc_fail;
  assign gie_clr = gie_evt_i.disable_irq_instruction || ack_i ||
                   any_trap_evt ||
                   (gie_evt_i.sw_write && !gie_evt_i.sw_value);
  assign gie_nxt = gie_clr ? 1'b0 :
                   (gie_evt_i.sw_write && gie_evt_i.sw_value) ? 1'b1 :
                   gie_r;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gie_r <= GIE_RESET;
    end else if (clk_en_i) begin
      gie_r <= gie_nxt;
    end
  end

  assign global_irq_enable_o = gie_r;
  assign pending_o = pend;

  // The enable flag moves only on a write or on one of the clear events.
  AST_GIE_SET: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (clk_en_i && gie_evt_i.sw_write && gie_evt_i.sw_value && !gie_clr)
    |=> global_irq_enable_o)
    else $error("global enable not set by write of one");

  AST_GIE_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (clk_en_i && !gie_evt_i.sw_write && !gie_clr)
    |=> $stable(global_irq_enable_o))
    else $error("global enable changed with no event");

  AST_GIE_CLR: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (clk_en_i && (ack_i || any_trap_evt ||
     gie_evt_i.disable_irq_instruction)) |=> !global_irq_enable_o)
    else $error("global enable survived a clearing event");

  AST_GIE_WR0: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (clk_en_i && gie_evt_i.sw_write && !gie_evt_i.sw_value)
    |=> !global_irq_enable_o)
    else $error("global enable survived a write of zero");

  // A low clock enable must hold every flag, pending ones included.
  AST_FROZEN: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !clk_en_i |=> ($stable(pending_o) && $stable(global_irq_enable_o)))
    else $error("state changed while the clock enable was low");

  AST_LEVEL_ORDER: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (|pick3) |-> (req_o.valid && req_o.level == LVL_3))
    else $error("lower level won over a pending level 3");

  AST_LVL0_IDLE: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    req_o.valid |-> (req_o.level != LVL_OFF))
    else $error("source at level zero presented");

  AST_RANK: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    req_o.valid |-> ((cand & ((N_SRC'(1) << req_o.id) - N_SRC'(1))) == '0))
    else $error("lower-ranked source chosen within a level");

  AST_IN_CAND: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    req_o.valid |-> cand[req_o.id])
    else $error("presented source is not a candidate");

  AST_TRAP_TOP: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (req_o.valid && req_o.trap) |-> req_o.level == LVL_3)
    else $error("trap presented below level 3");

  AST_WDT_REQ: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (clk_en_i && watchdog_timeout_i && !watchdog_reset_select_i)
    |=> pending_o[WDT_SRC])
    else $error("watchdog timeout did not post a request");

  AST_WDT_NO_POST: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (clk_en_i && watchdog_timeout_i && watchdog_reset_select_i &&
     !src_pulse_i[WDT_SRC] && !pending_o[WDT_SRC]) |=> !pending_o[WDT_SRC])
    else $error("reset-selected timeout posted a request");

  AST_GATED: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (req_o.valid && !global_irq_enable_o) |-> req_o.trap)
    else $error("maskable request presented with global enable clear");

  AST_TRAP_SHOWN: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (|(pending_o & src_is_trap_i)) |-> req_o.valid)
    else $error("pending trap not presented");

  AST_FROM_PEND: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    req_o.valid |-> pending_o[req_o.id])
    else $error("request presented for a source not pending");

endmodule : priority_interrupt_controller

`default_nettype wire

/* shared/irq_ctrl_pkg.sv */
package irq_ctrl_pkg;

  // Number of interrupt sources; index 0 has the highest fixed rank.
  localparam int unsigned NUM_SRC = 8;
  localparam int unsigned ID_W = 3;

  // Priority level codes.
  localparam logic [1:0] LVL_OFF = 2'h0;
  localparam logic [1:0] LVL_1 = 2'h1;
  localparam logic [1:0] LVL_2 = 2'h2;
  localparam logic [1:0] LVL_3 = 2'h3;

  // Reset values.
  localparam logic GIE_RESET = 1'b0;
  localparam logic PEND_RESET = 1'b0;

  // Global enable event group.
  typedef struct packed {
    logic sw_write;
    logic sw_value;
    logic disable_irq_instruction;
    logic trap_instruction;
    logic illegal_trap;
    logic prim_osc_fail;
    logic wdt_osc_fail;
  } gie_evt_t;

  // Request presented to the processor core.
  typedef struct packed {
    logic valid;
    logic trap;
    logic [1:0] level;
    logic [ID_W-1:0] id;
  } irq_req_t;

endpackage : irq_ctrl_pkg

/* rtl/irq_pend_bit.sv */
`timescale 1ns/1ps
`default_nettype none

// One pending request flag. A new pulse wins over any clear in the same
// cycle so that no event is lost.
module irq_pend_bit
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // Events
  input wire logic pulse_i,
  input wire logic ack_clr_i,
  input wire logic sw_clr_i,
  // State
  output logic pend_o
);

  logic pend_r;
  logic pend_nxt;

  assign pend_nxt = pulse_i ? 1'b1 :
                    (ack_clr_i || sw_clr_i) ? 1'b0 : pend_r;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_r <= PEND_RESET;
    end else if (clk_en_i) begin
      pend_r <= pend_nxt;
    end
  end

  assign pend_o = pend_r;

  AST_PULSE_SETS: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (clk_en_i && pulse_i) |=> pend_o)
    else $error("pending flag missed a request pulse");

  AST_ACK_CLEARS: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (clk_en_i && ack_clr_i && !pulse_i) |=> !pend_o)
    else $error("pending flag not cleared by acknowledge");

  AST_SW_CLEARS: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (clk_en_i && sw_clr_i && !pulse_i) |=> !pend_o)
    else $error("pending flag not cleared by software zero");

endmodule : irq_pend_bit

`default_nettype wire

/* tb/core_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Processor core that takes the presented request after a chosen wait.
module core_model
  import irq_ctrl_pkg::*;
(
  // Clock and control
  input wire logic ref_clk_i,
  input wire logic ack_en_i,
  input wire logic [3:0] wait_i,
  // Controller side
  input wire irq_req_t req_i,
  output logic ack_o,
  output logic [ID_W-1:0] ack_id_o
);
  logic [3:0] cnt_r = 4'h0;
  logic ack_r = 1'b0;
  logic [ID_W-1:0] id_r = '0;

  assign ack_o = ack_r;
  assign ack_id_o = id_r;

  // The id lines toggle outside an acknowledge, so a stale id never helps.
  // The wait restarts whenever acknowledging stops, so no count is left over.
  always @(negedge ref_clk_i) begin
    ack_r <= 1'b0;
    id_r <= ~id_r;
    if (!ack_en_i || !req_i.valid) begin
      cnt_r <= 4'h0;
    end else if (!ack_r) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r >= wait_i) begin
        ack_r <= 1'b1;
        id_r <= req_i.id;
        cnt_r <= 4'h0;
      end
    end
  end
endmodule : core_model

`default_nettype wire

/* tb/priority_interrupt_controller_test.sv */
`timescale 1ns/1ps
`default_nettype none

module priority_interrupt_controller_test
  import irq_ctrl_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, wto = 1'b0, wsel = 1'b1, ack_en = 1'b0;
  logic en = 1'b1;
  logic [7:0] pls = '0, trp = '0, wz = '0;
  logic [15:0] lvl = '0;
  logic [3:0] wt = '0;
  gie_evt_t evt = '0;
  irq_req_t req;
  logic gie, wrst, ack;
  logic [7:0] pend;
  logic [ID_W-1:0] ack_id;
  int errors = 0, checked = 0, cycles = 0;
  always #25 clk = ~clk;
  priority_interrupt_controller dut (.ref_clk_i(clk), .rstn_i(rstn),
    .clk_en_i(en), .src_pulse_i(pls), .src_is_trap_i(trp),
    .src_level_i(lvl), .watchdog_timeout_i(wto),
    .watchdog_reset_select_i(wsel), .req_wr_zero_i(wz), .gie_evt_i(evt),
    .ack_i(ack), .ack_id_i(ack_id), .req_o(req), .global_irq_enable_o(gie),
    .pending_o(pend), .watchdog_reset_o(wrst));
  core_model core (.ref_clk_i(clk), .ack_en_i(ack_en), .wait_i(wt),
    .req_i(req), .ack_o(ack), .ack_id_o(ack_id));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Every source, clear and enable event is a single-cycle pulse.
  task automatic pp(input logic [7:0] p, z, input gie_evt_t e);
    pls = p;
    wz = z;
    evt = e;
    cyc(1);
    pls = '0;
    wz = '0;
    evt = '0;
  endtask : pp
  task automatic report_and_stop;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic t_enable;
    for (int k = 0; k < 5; k++) begin
      pp(8'h00, 8'h00, 7'h60);
      chk("gie_on", gie, 8'h01);
      pp(8'h00, 8'h00, 7'h01 << k);
      chk("gie_evt_off", gie, 8'h00);
    end
    pp(8'h00, 8'h00, 7'h60);
    pp(8'h00, 8'h00, 7'h40);
    chk("gie_wr0", gie, 8'h00);
    pp(8'h00, 8'h00, 7'h70);
    chk("gie_race", gie, 8'h00);
    $display("t_enable done");
  endtask : t_enable
  task automatic t_ack;
    lvl = 16'h0020;
    wt = 4'h2;
    ack_en = 1'b1;
    pp(8'h04, 8'h00, 7'h60);
    chk("pend_set", pend, 8'h04);
    chk("req_src2", req, {1'b1, 1'b0, LVL_2, 3'h2});
    cyc(6);
    chk("pend_ack", pend, 8'h00);
    chk("gie_ack", gie, 8'h00);
    ack_en = 1'b0;
    $display("t_ack done");
  endtask : t_ack
  task automatic t_prio;
    logic [2:0] id [4] = '{3'h5, 3'h6, 3'h4, 3'h3};
    logic [1:0] lv [4] = '{LVL_3, LVL_3, LVL_2, LVL_1};
    lvl = 16'h3e40;
    pp(8'h78, 8'h00, 7'h00);
    chk("masked", req.valid, 8'h00);
    pp(8'h00, 8'h00, 7'h60);
    for (int k = 0; k < 4; k++) begin
      chk("winner", req, {1'b1, 1'b0, lv[k], id[k]});
      pp(8'h00, 8'h01 << id[k], 7'h00);
    end
    chk("pend_wr0", pend, 8'h00);
    $display("t_prio done");
  endtask : t_prio
  task automatic t_trap;
    pp(8'h00, 8'h00, 7'h40);
    trp = 8'h80;
    lvl = 16'h4001;
    pp(8'h80, 8'h00, 7'h00);
    chk("trap_req", req, {1'b1, 1'b1, LVL_3, 3'h7});
    pp(8'h00, 8'h80, 7'h00);
    wsel = 1'b0;
    wto = 1'b1;
    #1 chk("wdt_no_rst", wrst, 8'h00);
    cyc(1);
    wto = 1'b0;
    chk("wdt_pend", pend, 8'h01);
    chk("wdt_masked", req.valid, 8'h00);
    pp(8'h00, 8'h00, 7'h60);
    chk("wdt_req", req, {1'b1, 1'b0, LVL_3, 3'h0});
    pp(8'h00, 8'h01, 7'h00);
    wsel = 1'b1;
    wto = 1'b1;
    #1 chk("wdt_rst", wrst, 8'h01);
    cyc(1);
    wto = 1'b0;
    chk("wdt_no_post", pend, 8'h00);
    pp(8'h80, 8'h00, 7'h00);
    rstn = 1'b0;
    cyc(1);
    chk("rst_gie", gie, 8'h00);
    chk("rst_pend", pend, 8'h00);
    rstn = 1'b1;
    $display("t_trap done");
  endtask : t_trap
  // Source 1 sits at level 0 here, so it may pend but never be presented.
  task automatic t_freeze;
    en = 1'b0;
    pp(8'h02, 8'h00, 7'h60);
    chk("frz_pend", pend, 8'h00);
    chk("frz_gie", gie, 8'h00);
    en = 1'b1;
    pp(8'h02, 8'h02, 7'h60);
    chk("set_wins", pend, 8'h02);
    chk("gie_back", gie, 8'h01);
    chk("lvl0_idle", req.valid, 8'h00);
    pp(8'h00, 8'h02, 7'h00);
    chk("lvl0_clr", pend, 8'h00);
    $display("t_freeze done");
  endtask : t_freeze
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    cyc(4);
    rstn = 1'b1;
    t_enable();
    t_ack();
    t_prio();
    t_trap();
    t_freeze();
    report_and_stop();
  end
endmodule : priority_interrupt_controller_test

`default_nettype wire
